/* hdl/prm_pkg.sv */
// package for the polygon raster mode and depth offset unit
// Summary of operation
// R1 - vertex mode emits only boundary-start vertices as points, no fill
// R2 - edge mode emits boundary edges as lines, no interior fragments
// R3 - edge mode restarts line stipple on first edge of each polygon only
// R4 - mode is applied last, after lighting, clipping and culling upstream
// R5 - area antialiasing only in fill mode; point or line antialias otherwise
// R6 - offset equals max slope times factor plus resolvable step times units
// R7 - max slope is root of squared gradients or larger absolute gradient
// R8 - slope for larger polygons lies within its sub-triangle slope range
// R9 - float depth: resolvable step is two to exponent minus mantissa bits
// R10 - fixed depth: one constant resolvable step over whole range
// R11 - polygons differing by one resolvable step get distinct depths
// R12 - without depth storage the units term has no defined value
// R13 - fixed depth: slope and offset both in unit range
// R14 - three offset enables, one per mode; active one adds offset
// R15 - fragment depth clamped to unit range after offset
// R16 - multisample: emit fragment for pixel with any covered sample
// R17 - multisample: culled polygons emit nothing; stipple still discards
// R18 - coverage bit one for each passing sample, zero otherwise
// R19 - attributes evaluated at sample location or shared pixel point
// R20 - polygon multisample rules only in fill mode
// R21 - reset: stipple ones, stipple and antialias off, fill, zero offsets
// R22 - separate front and back modes chosen by polygon facing
// R23 - mode updates carry a face selector; only chosen faces change
// R24 - offset computed once per polygon before its fragments
package prm_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_FACTOR = 8'h08;
  localparam logic [7:0] OFF_UNITS = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_STIP = 8'h80;
  // control field positions
  localparam int B_OFS_VTX = 0;
  localparam int B_OFS_EDGE = 1;
  localparam int B_OFS_FILL = 2;
  localparam int B_STIP_EN = 3;
  localparam int B_AREA_AA = 4;
  localparam int B_MS_EN = 5;
  localparam int B_SBUF_ONE = 6;
  localparam int B_DEPTH_FLT = 7;
  localparam int B_DEPTH_ON = 8;
  localparam int B_EVAL_SMP = 9;
  localparam int CTRL_W = 10;
  // mode register fields
  localparam int B_FACE_LO = 0;
  localparam int B_MODE_LO = 2;
  localparam int B_BACK_LO = 4;
  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h100;
  localparam logic [15:0] FACTOR_RST = 16'h0000;
  localparam logic [15:0] UNITS_RST = 16'h0000;
  localparam logic [31:0] STIP_RST = 32'hFFFFFFFF;
  // factor is signed with this many fraction bits
  localparam int FACTOR_FRAC = 8;
  // face selector codes
  localparam logic [1:0] FACE_FRONT = 2'h1;
  localparam logic [1:0] FACE_BACK = 2'h2;
  localparam logic [1:0] FACE_BOTH = 2'h3;
  // raster styles, also used as fragment kind tags
  typedef enum logic [1:0] {
    RS_VERTEX = 2'h0,
    RS_EDGE = 2'h1,
    RS_FILL = 2'h2
  } prm_style_type;
  localparam prm_style_type MODE_RST = RS_FILL;
  // polygon sequencer, gray coded except the two-bit step from emit back to idle
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CALC = 2'b01,
    ST_EMIT = 2'b11
  } prm_state_type;
endpackage

/* hdl/prm_raster_option.sv */
// polygon raster mode, depth offset and multisample coverage unit
`timescale 1ns/10ps
`default_nettype none
module prm_raster_option #(
  parameter int ZW = 24,
  parameter int MANT = 23,
  parameter int NS = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic prim_valid,
  output logic prim_ready,
  input wire logic prim_back,
  input wire logic prim_culled,
  input wire logic signed [31:0] prim_dzdx,
  input wire logic signed [31:0] prim_dzdy,
  input wire logic signed [7:0] prim_zexp,
  input wire logic frag_valid,
  output logic frag_ready,
  input wire logic [1:0] frag_kind,
  input wire logic [9:0] frag_x,
  input wire logic [9:0] frag_y,
  input wire logic [ZW-1:0] frag_z,
  input wire logic frag_center,
  input wire logic [NS-1:0] frag_cov,
  input wire logic frag_last,
  output logic out_valid,
  input wire logic out_ready,
  output logic [9:0] out_x,
  output logic [9:0] out_y,
  output logic [ZW-1:0] out_z,
  output logic [NS-1:0] out_cov,
  output logic [1:0] face_raster_style_select,
  output logic out_area_aa,
  output logic out_ms_poly,
  output logic out_eval_sample,
  output logic out_stipple_restart
);

  // refuse widths the offset datapath cannot hold
  if (ZW < 8 || ZW > 30 || MANT < 1 || MANT > 52 || NS < 1 || NS > 32) begin : g_chk
    $error("prm_raster_option: unsupported parameter value");
  end

  localparam int OW = 48;

  logic [prm_pkg::CTRL_W-1:0] ctrl_q;
  prm_pkg::prm_style_type front_q;
  prm_pkg::prm_style_type back_q;
  logic signed [15:0] factor_q;
  logic signed [15:0] units_q;
  logic [31:0] stip_q [32];
  prm_pkg::prm_state_type state_q;
  logic back_q_poly;
  logic culled_q;
  logic signed [31:0] dzdx_q;
  logic signed [31:0] dzdy_q;
  logic signed [7:0] zexp_q;
  logic signed [OW-1:0] ofs_q;
  logic first_edge_q;
  logic [15:0] poly_cnt_q;
  logic [31:0] rdata_d;
  logic hit_d;
  logic wr_en;
  logic [4:0] stip_idx;

  // access edge of an apb write; pready is high in every access phase
  assign wr_en = psel & penable & pwrite & pready;
  assign stip_idx = paddr[6:2];

  // read mux and address decode
  always_comb begin
    rdata_d = 32'h00000000;
    hit_d = 1'b1;
    if (paddr[7]) begin
      rdata_d = stip_q[stip_idx];
    end else begin
      case (paddr)
        prm_pkg::OFF_CTRL: rdata_d = {{(32-prm_pkg::CTRL_W){1'b0}}, ctrl_q};
        prm_pkg::OFF_MODE: rdata_d = {26'h0, back_q, front_q, 2'h0};
        prm_pkg::OFF_FACTOR: rdata_d = {{16{factor_q[15]}}, factor_q};
        prm_pkg::OFF_UNITS: rdata_d = {{16{units_q[15]}}, units_q};
        prm_pkg::OFF_STATUS: rdata_d = {poly_cnt_q, 13'h0, first_edge_q, state_q};
        default: hit_d = 1'b0;
      endcase
    end
  end

  // zero wait state slave: answer prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_d;
      prdata <= (psel & ~penable & ~pwrite) ? rdata_d : 32'h00000000;
    end
  end

  // control, factor and units registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= prm_pkg::CTRL_RST; // R21
      factor_q <= prm_pkg::FACTOR_RST; // R21
      units_q <= prm_pkg::UNITS_RST; // R21
    end else if (wr_en) begin
      if (paddr == prm_pkg::OFF_CTRL) begin
        ctrl_q <= pwdata[prm_pkg::CTRL_W-1:0];
      end
      if (paddr == prm_pkg::OFF_FACTOR) begin
        factor_q <= pwdata[15:0];
      end
      if (paddr == prm_pkg::OFF_UNITS) begin
        units_q <= pwdata[15:0];
      end
    end
  end

  // per-face styles; an update replaces only the selected faces
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      front_q <= prm_pkg::MODE_RST; // R21
      back_q <= prm_pkg::MODE_RST; // R21
    end else if (wr_en && paddr == prm_pkg::OFF_MODE &&
                 pwdata[prm_pkg::B_MODE_LO +: 2] != 2'h3) begin
      if (pwdata[prm_pkg::B_FACE_LO +: 2] == prm_pkg::FACE_FRONT ||
          pwdata[prm_pkg::B_FACE_LO +: 2] == prm_pkg::FACE_BOTH) begin
        front_q <= prm_pkg::prm_style_type'(pwdata[prm_pkg::B_MODE_LO +: 2]); // R23
      end
      if (pwdata[prm_pkg::B_FACE_LO +: 2] == prm_pkg::FACE_BACK ||
          pwdata[prm_pkg::B_FACE_LO +: 2] == prm_pkg::FACE_BOTH) begin
        back_q <= prm_pkg::prm_style_type'(pwdata[prm_pkg::B_MODE_LO +: 2]); // R23
      end
    end
  end

  // stipple rows, one word per row
  for (genvar gi = 0; gi < 32; gi++) begin : g_stip
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        stip_q[gi] <= prm_pkg::STIP_RST; // R21
      end else if (wr_en && paddr[7] && stip_idx == 5'(gi)) begin
        stip_q[gi] <= pwdata;
      end
    end
  end

  // active style of the current polygon, chosen by its facing
  prm_pkg::prm_style_type act_style;
  assign act_style = back_q_poly ? back_q : front_q; // R22

  // max slope by the larger absolute gradient, which stays in range
  logic [31:0] adx;
  logic [31:0] ady;
  logic [31:0] mslope;
  assign adx = dzdx_q[31] ? 32'(-dzdx_q) : 32'(dzdx_q);
  assign ady = dzdy_q[31] ? 32'(-dzdy_q) : 32'(dzdy_q);
  assign mslope = (adx > ady) ? adx : ady; // R7 R8 R13

  // resolvable step as a shift of one depth lsb
  logic signed [9:0] rshift_raw;
  logic [4:0] rshift;
  always_comb begin
    rshift_raw = 10'(ZW - MANT) + 10'(zexp_q);
    rshift = 5'h00; // fixed point: one constant lsb step
    if (ctrl_q[prm_pkg::B_DEPTH_FLT]) begin
      // never below one lsb, so a step still separates depths
      if (rshift_raw > 10'(ZW)) begin
        rshift = 5'(ZW); // R9
      end else if (rshift_raw > 10'sh000) begin
        rshift = rshift_raw[4:0]; // R9 R11
      end
    end
  end

  // offset equation, slope term plus units term
  logic signed [OW-1:0] slope_term;
  logic signed [OW-1:0] unit_term;
  logic signed [OW-1:0] ofs_d;
  logic signed [49:0] prod;
  always_comb begin
    prod = 50'(signed'({1'b0, mslope}) * factor_q);
    slope_term = OW'(prod >>> prm_pkg::FACTOR_FRAC); // R6 R13
    unit_term = OW'(units_q) <<< rshift; // R6 R10
    if (!ctrl_q[prm_pkg::B_DEPTH_ON]) begin
      unit_term = '0; // R12
    end
    ofs_d = slope_term + unit_term; // R6
  end

  // polygon sequencer: take polygon, compute offset, stream fragments
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= prm_pkg::ST_IDLE;
      back_q_poly <= 1'b0;
      culled_q <= 1'b0;
      dzdx_q <= '0;
      dzdy_q <= '0;
      zexp_q <= '0;
      ofs_q <= '0;
      poly_cnt_q <= 16'h0000;
    end else begin
      case (state_q)
        prm_pkg::ST_IDLE: begin
          if (prim_valid) begin
            back_q_poly <= prim_back;
            culled_q <= prim_culled; // R4
            dzdx_q <= prim_dzdx;
            dzdy_q <= prim_dzdy;
            zexp_q <= prim_zexp;
            state_q <= prm_pkg::ST_CALC;
          end
        end
        prm_pkg::ST_CALC: begin
          ofs_q <= ofs_d; // R24
          state_q <= prm_pkg::ST_EMIT;
        end
        prm_pkg::ST_EMIT: begin
          if (frag_valid && frag_ready && frag_last) begin
            poly_cnt_q <= poly_cnt_q + 16'h0001;
            state_q <= prm_pkg::ST_IDLE;
          end
        end
        default: state_q <= prm_pkg::ST_IDLE;
      endcase
    end
  end

  assign prim_ready = (state_q == prm_pkg::ST_IDLE);
  assign frag_ready = (state_q == prm_pkg::ST_EMIT) & (~out_valid | out_ready);

  // fragment selection
  logic is_fill;
  logic ms_on;
  logic keep_d;
  logic ofs_en;
  logic stip_bit;
  logic signed [OW-1:0] zsum;
  logic [ZW-1:0] zclamp;
  logic [NS-1:0] cov_d;
  always_comb begin
    is_fill = (act_style == prm_pkg::RS_FILL);
    ms_on = ctrl_q[prm_pkg::B_MS_EN] & ctrl_q[prm_pkg::B_SBUF_ONE];
    stip_bit = stip_q[frag_y[4:0]][frag_x[4:0]];
    // only fragments of the active style survive
    keep_d = (frag_kind == act_style) & ~culled_q; // R1 R2 R17
    if (is_fill) begin
      if (ms_on) begin
        keep_d = keep_d & (|frag_cov); // R16 R20
      end else begin
        keep_d = keep_d & frag_center;
      end
      if (ctrl_q[prm_pkg::B_STIP_EN] && !stip_bit) begin
        keep_d = 1'b0; // R17
      end
    end
    case (act_style)
      prm_pkg::RS_VERTEX: ofs_en = ctrl_q[prm_pkg::B_OFS_VTX]; // R14
      prm_pkg::RS_EDGE: ofs_en = ctrl_q[prm_pkg::B_OFS_EDGE]; // R14
      default: ofs_en = ctrl_q[prm_pkg::B_OFS_FILL]; // R14
    endcase
    zsum = OW'({1'b0, frag_z}) + (ofs_en ? ofs_q : OW'(0));
    if (zsum < 0) begin
      zclamp = '0; // R15
    end else if (zsum > OW'({ZW{1'b1}})) begin
      zclamp = '1; // R15
    end else begin
      zclamp = zsum[ZW-1:0];
    end
    // point and line multisample coverage is passed through as given
    cov_d = (ms_on || !is_fill) ? frag_cov : '1; // R18
  end

  // first edge of each polygon restarts the line stipple counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_edge_q <= 1'b0;
    end else if (prim_valid && prim_ready) begin
      first_edge_q <= 1'b1; // R3
    end else if (frag_valid && frag_ready && keep_d &&
                 act_style == prm_pkg::RS_EDGE) begin
      first_edge_q <= 1'b0; // R3
    end
  end

  // output stage, all from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_x <= '0;
      out_y <= '0;
      out_z <= '0;
      out_cov <= '0;
      face_raster_style_select <= prm_pkg::MODE_RST;
      out_area_aa <= 1'b0;
      out_ms_poly <= 1'b0;
      out_eval_sample <= 1'b0;
      out_stipple_restart <= 1'b0;
    end else if (frag_valid && frag_ready) begin
      out_valid <= keep_d;
      out_x <= frag_x;
      out_y <= frag_y;
      out_z <= zclamp;
      out_cov <= cov_d;
      face_raster_style_select <= act_style; // R4
      out_area_aa <= is_fill & ctrl_q[prm_pkg::B_AREA_AA]; // R5
      out_ms_poly <= is_fill & ms_on; // R20
      out_eval_sample <= is_fill & ms_on & ctrl_q[prm_pkg::B_EVAL_SMP]; // R19
      out_stipple_restart <= first_edge_q & (act_style == prm_pkg::RS_EDGE); // R3
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* testbench/prm_raster_option_monitor.sv */
// checker for the polygon raster option unit, bound to its top module
`timescale 1ns/10ps
`default_nettype none
module prm_raster_option_monitor #(
  parameter int ZW = 24
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic prim_valid,
  input wire logic prim_ready,
  input wire logic frag_valid,
  input wire logic frag_ready,
  input wire logic frag_last,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [ZW-1:0] out_z,
  input wire logic [1:0] face_raster_style_select,
  input wire logic out_area_aa,
  input wire logic out_ms_poly,
  input wire logic out_stipple_restart
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // polygon steps: accepted, offset worked out, fragments, last one taken
  sequence s_poly_taken;
    prim_valid && prim_ready;
  endsequence
  sequence s_calc_gap;
    !prim_ready && !frag_ready;
  endsequence
  sequence s_last_taken;
    frag_valid && frag_ready && frag_last;
  endsequence
  a_apb_zero_wait: assert property (
    psel && !penable |=> pready) else $error("no ready in access cycle");
  a_ready_in_access: assert property (
    pready |-> psel && penable && !$past(penable)) else $error("ready outside access");
  a_rdata_idle_zero: assert property (
    !pready |-> prdata == 32'h0) else $error("read data outside access");
  a_slverr_with_ready: assert property (
    pslverr |-> pready) else $error("error without ready");
  a_offset_before_frag: assert property (
    s_poly_taken |=> s_calc_gap) else $error("fragment taken before offset");
  a_idle_after_last: assert property (
    s_last_taken |=> ##[0:2] prim_ready) else $error("no return to idle");
  a_frag_gate: assert property (
    frag_ready |-> !prim_ready && (!out_valid || out_ready)) else $error("taken while blocked");
  a_out_hold: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_z) && $stable(face_raster_style_select))
    else $error("output changed while stalled");
  a_area_aa_fill: assert property (
    out_valid && out_area_aa |-> face_raster_style_select == prm_pkg::RS_FILL)
    else $error("area antialias outside fill");
  a_ms_fill_only: assert property (
    out_valid && out_ms_poly |-> face_raster_style_select == prm_pkg::RS_FILL)
    else $error("polygon multisample outside fill");
  a_restart_edge: assert property (
    out_valid && out_stipple_restart |-> face_raster_style_select == prm_pkg::RS_EDGE)
    else $error("stipple restart outside edge style");
endmodule
bind prm_raster_option prm_raster_option_monitor #(.ZW(ZW)) u_mon (.pclk, .presetn, .psel,
  .penable, .prdata, .pready, .pslverr, .prim_valid, .prim_ready, .frag_valid, .frag_ready,
  .frag_last, .out_valid, .out_ready, .out_z, .face_raster_style_select, .out_area_aa,
  .out_ms_poly, .out_stipple_restart);
`default_nettype wire

/* testbench/prm_frag_sink.sv */
// downstream fragment consumer, ready at once or on alternate cycles
`timescale 1ns/10ps
`default_nettype none
module prm_frag_sink (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  output logic out_ready
);
  logic tog_q;
  // toggle gives a short stall pattern without a long wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tog_q <= 1'b0;
    end else begin
      tog_q <= ~tog_q;
    end
  end
  // held low in reset, since nothing can be delivered then
  assign out_ready = presetn && (!slow || tog_q);
endmodule
`default_nettype wire

/* testbench/polygon_raster_mode_depth_offset_tb.sv */
// bench for the polygon raster option unit
`timescale 1ns/10ps
`default_nettype none
module polygon_raster_mode_depth_offset_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, prim_ready, frag_ready, out_valid, out_ready;
  logic prim_valid = 1'b0, prim_back = 1'b0, prim_culled = 1'b0, slow = 1'b0;
  logic signed [31:0] prim_dzdx = 32'sh0, prim_dzdy = 32'sh2;
  logic signed [7:0] prim_zexp = 8'sh0;
  logic frag_valid = 1'b0, frag_last = 1'b0;
  logic [1:0] frag_kind = 2'h0, face_raster_style_select;
  logic [9:0] frag_x = 10'h0, frag_y = 10'h0, out_x, out_y;
  logic [23:0] frag_z = 24'h0, out_z;
  logic [3:0] frag_cov = 4'h0, out_cov;
  logic frag_center = 1'b1, out_area_aa, out_ms_poly, out_stipple_restart, out_eval_sample;
  logic [39:0] rec, q[$];
  int n_fail = 0, check_count = 0, cyc = 0;
  // low position bits ride along so a swapped or stale fragment shows up
  assign rec = {2'h0, out_y[1:0], out_x[1:0], out_eval_sample, out_area_aa, out_ms_poly,
    out_stipple_restart, face_raster_style_select, out_cov, out_z};
  prm_raster_option #(.ZW(24), .MANT(23), .NS(4)) dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .prim_valid, .prim_ready,
    .prim_back, .prim_culled, .prim_dzdx, .prim_dzdy, .prim_zexp, .frag_valid, .frag_ready,
    .frag_kind, .frag_x, .frag_y, .frag_z, .frag_center, .frag_cov, .frag_last, .out_valid,
    .out_ready, .out_x, .out_y, .out_z, .out_cov, .face_raster_style_select,
    .out_area_aa, .out_ms_poly, .out_eval_sample, .out_stipple_restart);
  prm_frag_sink snk (.pclk, .presetn, .slow, .out_ready);
  // clock and hang guard
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      summarize();
    end
  end
  // record every delivered fragment
  always @(posedge pclk) begin
    if (presetn && out_valid === 1'b1 && out_ready === 1'b1) q.push_back(rec);
  end
  // f holds y[1:0], x[1:0], sample eval, area aa, ms poly, stipple restart
  function automatic logic [39:0] ex(input logic [7:0] f, input logic [1:0] s,
      input logic [3:0] c, input logic [23:0] z);
    return {2'h0, f, s, c, z};
  endfunction
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] e, input logic er);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    if (!w) chk("prdata", 40'(e), 40'(prdata));
    chk("pslverr", 40'(er), 40'(pslverr));
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, e, 1'b0);
  endtask
  task automatic poly(input logic b, input logic c, input logic signed [31:0] g,
      input logic signed [7:0] ze);
    prim_valid <= 1'b1;
    prim_back <= b;
    prim_culled <= c;
    prim_dzdx <= g;
    prim_zexp <= ze;
    @(posedge pclk);
    while (prim_ready !== 1'b1) @(posedge pclk);
    prim_valid <= 1'b0;
  endtask
  // valid stays up between fragments of one polygon
  task automatic frag(input logic [1:0] k, input logic [9:0] x, input logic [23:0] z,
      input logic [3:0] c, input logic l);
    frag_valid <= 1'b1;
    frag_kind <= k;
    frag_x <= x;
    frag_z <= z;
    frag_cov <= c;
    frag_last <= l;
    @(posedge pclk);
    while (frag_ready !== 1'b1) @(posedge pclk);
    if (l) frag_valid <= 1'b0;
  endtask
  task automatic get(input logic [39:0] e);
    int k;
    k = 0;
    while (q.size() == 0 && k < 40) begin
      @(posedge pclk);
      k++;
    end
    chk("fragment", e, q.size() > 0 ? q.pop_front() : 40'hX);
  endtask
  task automatic none;
    repeat (3) @(posedge pclk);
    chk("extra fragments", 40'h0, 40'(q.size()));
  endtask
  task automatic t_reset;
    rd(8'h00, 32'h100);
    rd(8'h04, 32'h28);
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h80, 32'hFFFFFFFF);
    rd(8'hFC, 32'hFFFFFFFF);
    apb(1'b0, 8'h40, 32'h0, 32'h0, 1'b1);
    $display("reset values done");
  endtask
  task automatic t_offset;
    slow <= 1'b1;
    wr(8'h08, 32'h100);
    wr(8'h0C, 32'h3);
    wr(8'h00, 32'h104);
    poly(1'b0, 1'b0, -32'sd5, 8'sh0);
    frag(2'h2, 10'h0, 24'd100, 4'h1, 1'b0);
    frag(2'h2, 10'h1, 24'hFFFFFC, 4'h1, 1'b1);
    get(ex(8'h00, 2'h2, 4'hF, 24'd108));
    get(ex(8'h10, 2'h2, 4'hF, 24'hFFFFFF));
    wr(8'h0C, 32'hFFFFFF38);
    poly(1'b0, 1'b0, 32'sd0, 8'sh0);
    frag(2'h2, 10'h2, 24'd100, 4'h1, 1'b1);
    get(ex(8'h20, 2'h2, 4'hF, 24'd0));
    slow <= 1'b0;
    none();
    $display("depth offset done");
  endtask
  task automatic t_modes;
    wr(8'h0C, 32'h1);
    wr(8'h00, 32'h101);
    wr(8'h04, 32'h3);
    rd(8'h04, 32'h0);
    poly(1'b1, 1'b0, 32'sd4, 8'sh0);
    frag(2'h2, 10'h0, 24'd50, 4'h3, 1'b0);
    frag(2'h0, 10'h1, 24'd50, 4'h3, 1'b1);
    get(ex(8'h10, 2'h0, 4'h3, 24'd55));
    wr(8'h04, 32'h5);
    rd(8'h04, 32'h4);
    poly(1'b0, 1'b0, 32'sd4, 8'sh0);
    frag(2'h1, 10'h0, 24'd10, 4'h1, 1'b0);
    frag(2'h2, 10'h1, 24'd10, 4'h1, 1'b0);
    frag(2'h1, 10'h2, 24'd20, 4'h2, 1'b1);
    get(ex(8'h01, 2'h1, 4'h1, 24'd10));
    get(ex(8'h20, 2'h1, 4'h2, 24'd20));
    poly(1'b1, 1'b0, 32'sd4, 8'sh0);
    frag(2'h0, 10'h3, 24'd50, 4'h3, 1'b1);
    get(ex(8'h30, 2'h0, 4'h3, 24'd55));
    poly(1'b0, 1'b1, 32'sd4, 8'sh0);
    frag(2'h1, 10'h0, 24'd10, 4'h1, 1'b1);
    none();
    $display("raster styles done");
  endtask
  task automatic t_ms;
    wr(8'h04, 32'hE);
    wr(8'h04, 32'hA);
    wr(8'h04, 32'hF);
    rd(8'h04, 32'h24);
    wr(8'h04, 32'hB);
    wr(8'h80, 32'hFFFFFFFE);
    wr(8'h00, 32'h378);
    poly(1'b0, 1'b0, 32'sd0, 8'sh0);
    frag(2'h2, 10'h0, 24'd30, 4'hF, 1'b0);
    frag(2'h2, 10'h1, 24'd30, 4'h5, 1'b0);
    frag(2'h2, 10'h2, 24'd30, 4'h0, 1'b1);
    get(ex(8'h1E, 2'h2, 4'h5, 24'd30));
    wr(8'h04, 32'h7);
    poly(1'b0, 1'b0, 32'sd0, 8'sh0);
    frag(2'h1, 10'h0, 24'd40, 4'h2, 1'b1);
    get(ex(8'h01, 2'h1, 4'h2, 24'd40));
    none();
    $display("multisample done");
  endtask
  task automatic t_float;
    wr(8'h04, 32'hB);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h184);
    poly(1'b0, 1'b0, 32'sd0, 8'sh2);
    frag(2'h2, 10'h1, 24'd100, 4'h1, 1'b1);
    get(ex(8'h10, 2'h2, 4'hF, 24'd108));
    poly(1'b0, 1'b0, 32'sd0, -8'sh1);
    frag(2'h2, 10'h1, 24'd100, 4'h1, 1'b1);
    get(ex(8'h10, 2'h2, 4'hF, 24'd101));
    wr(8'h00, 32'h004);
    poly(1'b0, 1'b0, 32'sd0, 8'sh2);
    frag(2'h2, 10'h1, 24'd100, 4'h1, 1'b1);
    get(ex(8'h10, 2'h2, 4'hF, 24'd100));
    // single-sample fill keeps only fragments whose centre is inside
    frag_center <= 1'b0;
    poly(1'b0, 1'b0, 32'sd0, 8'sh2);
    frag(2'h2, 10'h1, 24'd100, 4'h1, 1'b1);
    none();
    frag_center <= 1'b1;
    none();
    $display("float depth done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // reset for eight cycles, then every scenario in turn
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_offset();
    t_modes();
    t_ms();
    t_float();
    summarize();
  end
endmodule
`default_nettype wire
